// [phrs_params.svh]
// Purpose: constants for the hard-reset sequencer
// Assumes: clk_sys at 50 MHz
`ifndef PHRS_PARAMS_SVH
`define PHRS_PARAMS_SVH

// -----------------------------------------------------------------
// clock and times
// -----------------------------------------------------------------
`define PHRS_CLK_HZ 50000000
`define PHRS_SUPPLY_RESET_DELAY_US 25
`define PHRS_DISCHARGE_TIME_LIMIT_US 650
`define PHRS_SOURCE_RECOVERY_DELAY_US 660
`define PHRS_SOURCE_TURN_ON_LIMIT_US 275
`define PHRS_CYC_PER_US (`PHRS_CLK_HZ / 1000000)
`define PHRS_SUPPLY_RESET_DELAY_CYC (`PHRS_SUPPLY_RESET_DELAY_US * `PHRS_CYC_PER_US)
`define PHRS_DISCHARGE_TIME_LIMIT_CYC (`PHRS_DISCHARGE_TIME_LIMIT_US * `PHRS_CYC_PER_US)
`define PHRS_SOURCE_RECOVERY_DELAY_CYC (`PHRS_SOURCE_RECOVERY_DELAY_US * `PHRS_CYC_PER_US)
`define PHRS_SOURCE_TURN_ON_LIMIT_CYC (`PHRS_SOURCE_TURN_ON_LIMIT_US * `PHRS_CYC_PER_US)
`define PHRS_TMR_W 32

// -----------------------------------------------------------------
// register map (word addresses)
// -----------------------------------------------------------------
`define PHRS_ADDR_W 4
`define PHRS_REG_CTRL 4'h0
`define PHRS_REG_STATUS 4'h1
`define PHRS_REG_IRQ_STAT 4'h2
`define PHRS_REG_IRQ_MASK 4'h3
`define PHRS_CTRL_ENABLE_BIT 0
`define PHRS_CTRL_RESET_VAL 32'h0000_0001
`define PHRS_IRQ_W 4
`define PHRS_IRQ_DONE 0
`define PHRS_IRQ_DISCH_TO 1
`define PHRS_IRQ_TURNON_TO 2
`define PHRS_IRQ_HR_RX 3

`endif

// [phrs_pkg.sv]
// Purpose: types for the hard-reset sequencer
// Assumes: nothing
// Notes: state enumeration only
package phrs_pkg;
	typedef enum logic [2:0] {
		PHRS_IDLE,
		PHRS_WAIT_PS,
		PHRS_DISCHARGE,
		PHRS_RECOVER,
		PHRS_TURN_ON
	} phrs_state_t;
endpackage

// [phrs_timer.sv]
// Purpose: loadable down-counter
// Assumes: load has priority over count
// Notes: expired is a one-cycle pulse at the last count
`timescale 1ns/1ps
`include "phrs_params.svh"
module phrs_timer #(
	parameter int W = `PHRS_TMR_W
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic stop,
	output logic running,
	output logic expired
);
	logic [W-1:0] cnt_q;
	logic run_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (load) begin
			cnt_q <= (load_val == '0) ? W'(1) : load_val;
			run_q <= 1'b1;
		end else if (stop) begin
			run_q <= 1'b0;
		end else if (run_q) begin
			cnt_q <= cnt_q - W'(1);
			if (cnt_q == W'(1)) begin
				run_q <= 1'b0;
			end
		end
	end

	assign running = run_q;
	// not gated by load or stop: the sequencer reloads on expiry, gating would loop
	assign expired = run_q && (cnt_q == W'(1));
endmodule // phrs_timer

// [phrs_sequencer.sv]
// Purpose: source-side hard-reset power sequencer
// Assumes: policy engine strobes are on clk_sys; supply confirmations are pins
// Notes: one timer reused per phase, loaded from module parameters
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "phrs_params.svh"
module phrs_sequencer #(
	parameter int unsigned SUPPLY_RESET_DELAY_CYC = `PHRS_SUPPLY_RESET_DELAY_CYC,
	parameter int unsigned DISCHARGE_TIME_LIMIT_CYC = `PHRS_DISCHARGE_TIME_LIMIT_CYC,
	parameter int unsigned SOURCE_RECOVERY_DELAY_CYC = `PHRS_SOURCE_RECOVERY_DELAY_CYC,
	parameter int unsigned SOURCE_TURN_ON_LIMIT_CYC = `PHRS_SOURCE_TURN_ON_LIMIT_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic hard_reset_sent,
	input wire logic hard_reset_received,
	input wire logic vbus_at_safe_zero_level,
	input wire logic vbus_at_safe_default_level,
	output logic supply_reset_cmd,
	output logic vbus_enable,
	output logic sequence_busy,
	output logic sequence_done,
	input wire logic [`PHRS_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq
);
	import phrs_pkg::*;

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	logic [1:0] zero_sync_q;
	logic [1:0] dflt_sync_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			zero_sync_q <= 2'b00;
			dflt_sync_q <= 2'b00;
		end else begin
			zero_sync_q <= {zero_sync_q[0], vbus_at_safe_zero_level};
			dflt_sync_q <= {dflt_sync_q[0], vbus_at_safe_default_level};
		end
	end

	logic at_zero;
	logic at_dflt;
	assign at_zero = zero_sync_q[1];
	assign at_dflt = dflt_sync_q[1];

	// -----------------------------------------------------------------
	// control register
	// -----------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic enable;
	assign enable = ctrl_q[`PHRS_CTRL_ENABLE_BIT];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= `PHRS_CTRL_RESET_VAL;
		end else if (reg_wr && reg_addr == `PHRS_REG_CTRL) begin
			ctrl_q <= {31'h0, reg_wdata[`PHRS_CTRL_ENABLE_BIT]};
		end
	end

	// -----------------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------------
	phrs_state_t state_q;
	logic tmr_load;
	logic [`PHRS_TMR_W-1:0] tmr_val;
	logic tmr_stop;
	logic tmr_exp;
	logic trig;
	logic ev_done;
	logic ev_disch_to;
	logic ev_turnon_to;
	logic disch_to_q;
	logic turnon_to_q;

	// either a sent or a received hard reset starts the same delay
	assign trig = enable && (hard_reset_sent || hard_reset_received);

	always_comb begin
		tmr_load = 1'b0;
		tmr_val = '0;
		tmr_stop = 1'b0;
		unique case (state_q)
			PHRS_IDLE: begin
				if (trig) begin
					tmr_load = 1'b1;
					tmr_val = `PHRS_TMR_W'(SUPPLY_RESET_DELAY_CYC);
				end
			end
			PHRS_WAIT_PS: begin
				if (tmr_exp) begin
					tmr_load = 1'b1;
					tmr_val = `PHRS_TMR_W'(DISCHARGE_TIME_LIMIT_CYC);
				end
			end
			PHRS_DISCHARGE: begin
				// recovery delay counts from the moment vbus is confirmed low, or from the discharge limit running out
				if (at_zero || tmr_exp) begin
					tmr_load = 1'b1;
					tmr_val = `PHRS_TMR_W'(SOURCE_RECOVERY_DELAY_CYC);
				end
			end
			PHRS_RECOVER: begin
				if (tmr_exp) begin
					tmr_load = 1'b1;
					tmr_val = `PHRS_TMR_W'(SOURCE_TURN_ON_LIMIT_CYC);
				end
			end
			PHRS_TURN_ON: begin
				tmr_stop = at_dflt;
			end
		endcase
	end

	phrs_timer #(
		.W(`PHRS_TMR_W)
	) u_timer (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.load(tmr_load),
		.load_val(tmr_val),
		.stop(tmr_stop),
		.running(),
		.expired(tmr_exp)
	);

	assign ev_disch_to = (state_q == PHRS_DISCHARGE) && !at_zero && tmr_exp;
	assign ev_turnon_to = (state_q == PHRS_TURN_ON) && !at_dflt && tmr_exp;
	assign ev_done = (state_q == PHRS_TURN_ON) && (at_dflt || tmr_exp);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= PHRS_IDLE;
		end else begin
			unique case (state_q)
				PHRS_IDLE: if (trig) state_q <= PHRS_WAIT_PS;
				PHRS_WAIT_PS: if (tmr_exp) state_q <= PHRS_DISCHARGE;
				PHRS_DISCHARGE: if (at_zero || tmr_exp) state_q <= PHRS_RECOVER;
				PHRS_RECOVER: if (tmr_exp) state_q <= PHRS_TURN_ON;
				PHRS_TURN_ON: if (ev_done) state_q <= PHRS_IDLE;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// outputs to the supply
	// -----------------------------------------------------------------
	logic reset_cmd_q;
	logic vbus_en_q;
	logic busy_q;
	logic done_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reset_cmd_q <= 1'b0;
			vbus_en_q <= 1'b1;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			// reset order held through discharge so the supply keeps vbus low
			reset_cmd_q <= (state_q == PHRS_WAIT_PS && tmr_exp) ||
				(state_q == PHRS_DISCHARGE && !(at_zero || tmr_exp));
			if (state_q == PHRS_WAIT_PS && tmr_exp) begin
				vbus_en_q <= 1'b0;
			end else if (state_q == PHRS_RECOVER && tmr_exp) begin
				vbus_en_q <= 1'b1;
			end
			busy_q <= (state_q != PHRS_IDLE) || trig;
			done_q <= ev_done;
		end
	end

	assign supply_reset_cmd = reset_cmd_q;
	assign vbus_enable = vbus_en_q;
	assign sequence_busy = busy_q;
	assign sequence_done = done_q;

	// -----------------------------------------------------------------
	// timeout flags and interrupt
	// -----------------------------------------------------------------
	logic [`PHRS_IRQ_W-1:0] irq_set;
	logic [`PHRS_IRQ_W-1:0] irq_stat_q;
	logic [`PHRS_IRQ_W-1:0] irq_mask_q;

	always_comb begin
		irq_set = '0;
		irq_set[`PHRS_IRQ_DONE] = ev_done;
		irq_set[`PHRS_IRQ_DISCH_TO] = ev_disch_to;
		irq_set[`PHRS_IRQ_TURNON_TO] = ev_turnon_to;
		irq_set[`PHRS_IRQ_HR_RX] = enable && hard_reset_received && state_q == PHRS_IDLE;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			disch_to_q <= 1'b0;
			turnon_to_q <= 1'b0;
		end else begin
			// live flags cleared when a new sequence starts
			if (ev_disch_to) disch_to_q <= 1'b1;
			else if (state_q == PHRS_IDLE && trig) disch_to_q <= 1'b0;
			if (ev_turnon_to) turnon_to_q <= 1'b1;
			else if (state_q == PHRS_IDLE && trig) turnon_to_q <= 1'b0;
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_stat_q <= '0;
		end else if (reg_wr && reg_addr == `PHRS_REG_IRQ_STAT) begin
			irq_stat_q <= (irq_stat_q & ~reg_wdata[`PHRS_IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_mask_q <= '0;
		end else if (reg_wr && reg_addr == `PHRS_REG_IRQ_MASK) begin
			irq_mask_q <= reg_wdata[`PHRS_IRQ_W-1:0];
		end
	end

	// a set mask bit hides its status bit from the interrupt
	assign irq = |(irq_stat_q & ~irq_mask_q);

	// -----------------------------------------------------------------
	// read port
	// -----------------------------------------------------------------
	logic [31:0] rdata_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`PHRS_REG_CTRL: rdata_q <= ctrl_q;
				`PHRS_REG_STATUS: rdata_q <= {23'h0, turnon_to_q, disch_to_q, at_dflt,
					at_zero, vbus_en_q, reset_cmd_q, state_q};
				`PHRS_REG_IRQ_STAT: rdata_q <= {28'h0, irq_stat_q};
				`PHRS_REG_IRQ_MASK: rdata_q <= {28'h0, irq_mask_q};
				default: rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata = rdata_q;
endmodule // phrs_sequencer

// [phrs_seq_properties.sv]
// Purpose: port checker for the hard-reset sequencer
// Assumes: one clock, rstn asynchronous active low
// Notes: one cycle of slack on the timer figures
`timescale 1ns/1ps
module phrs_seq_chk #(
	parameter int unsigned D = 8,
	parameter int unsigned R = 8
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic supply_reset_cmd,
	input wire logic vbus_enable,
	input wire logic sequence_busy,
	input wire logic sequence_done
);
	int unsigned wait_q;
	int unsigned off_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// ----
	// phase counters
	// ----
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wait_q <= 0;
			off_q <= 0;
		end else begin
			wait_q <= (sequence_busy && !supply_reset_cmd) ? wait_q + 1 : 0;
			off_q <= (!vbus_enable && !supply_reset_cmd) ? off_q + 1 : 0;
		end
	end
	a_order_not_early: assert property ($rose(supply_reset_cmd) |-> wait_q >= D - 1)
		else $error("supply order came early");
	a_order_in_time: assert property ($rose(sequence_busy) |-> ##[1:40] supply_reset_cmd)
		else $error("supply order missing");
	a_order_cuts_vbus: assert property (supply_reset_cmd |-> !vbus_enable && sequence_busy)
		else $error("order without vbus off");
	a_discharge_bounded: assert property ($rose(supply_reset_cmd) |-> ##[1:40] !supply_reset_cmd)
		else $error("discharge phase unbounded");
	a_recovery_held: assert property ($rose(vbus_enable) |-> off_q >= R - 1)
		else $error("vbus back before recovery");
	a_reapply_in_time: assert property ($fell(supply_reset_cmd) |-> ##[1:40] vbus_enable)
		else $error("vbus not reapplied");
	a_done_powered: assert property (sequence_done |-> vbus_enable ##1 !sequence_done)
		else $error("done pulse wrong");
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside slot");
endmodule // phrs_seq_chk

bind phrs_sequencer phrs_seq_chk #(
	.D(SUPPLY_RESET_DELAY_CYC),
	.R(SOURCE_RECOVERY_DELAY_CYC)
) u_chk (.clk_sys, .rstn, .reg_rd, .reg_rdata, .supply_reset_cmd, .vbus_enable,
	.sequence_busy, .sequence_done);

// [phrs_far_end.sv]
// Purpose: far port and rail model for the sequencer bench
// Assumes: rail moves one step a cycle, four steps full scale
// Notes: slow freezes the rail so both limits run out
`timescale 1ns/1ps
module phrs_far_end (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic hr_go,
	input wire logic slow,
	input wire logic supply_reset_cmd,
	input wire logic vbus_enable,
	output logic hard_reset_received,
	output logic vbus_at_safe_zero_level,
	output logic vbus_at_safe_default_level
);
	logic [2:0] lvl_q;
	// ----
	// rail and request
	// ----
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lvl_q <= 3'h4;
			hard_reset_received <= 1'b0;
		end else begin
			// sink sends, its supply prepared at once
			hard_reset_received <= hr_go;
			// sink draws nothing while the rail falls
			if (!slow && vbus_enable && lvl_q != 3'h4)
				lvl_q <= lvl_q + 3'h1;
			else if (!slow && supply_reset_cmd && lvl_q != 3'h0)
				lvl_q <= lvl_q - 3'h1;
		end
	end
	// sink ready once the rail is back
	assign vbus_at_safe_zero_level = !slow && lvl_q == 3'h0;
	assign vbus_at_safe_default_level = !slow && lvl_q == 3'h4;
endmodule // phrs_far_end

// [phrs_sequencer_test.sv]
// Purpose: self-checking bench for the hard-reset sequencer
// Assumes: short timer parameters, far port model on the pins
// Notes: rows cover both initiators, disabled and stuck rail
`timescale 1ns/1ps
`include "phrs_params.svh"
module phrs_sequencer_test;
	typedef struct packed {
		logic rx; logic en; logic slw; logic bsy; logic [3:0] msk; logic [3:0] stat;
	} phrs_row_t;
	logic clk_sys, rstn, hard_reset_sent, hard_reset_received, hr_go, slow;
	logic vbus_at_safe_zero_level, vbus_at_safe_default_level, supply_reset_cmd;
	logic vbus_enable, sequence_busy, sequence_done, reg_wr, reg_rd, irq;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	int error_cnt, cmp_count, cyc;
	phrs_row_t rows [4] = '{'{1'b0, 1'b1, 1'b0, 1'b1, 4'hf, 4'h1},
		'{1'b1, 1'b1, 1'b0, 1'b1, 4'hf, 4'h9}, '{1'b0, 1'b0, 1'b0, 1'b0, 4'hf, 4'h0},
		'{1'b0, 1'b1, 1'b1, 1'b1, 4'h6, 4'h6}};
	phrs_sequencer #(
		.SUPPLY_RESET_DELAY_CYC(10),
		.DISCHARGE_TIME_LIMIT_CYC(16),
		.SOURCE_RECOVERY_DELAY_CYC(12),
		.SOURCE_TURN_ON_LIMIT_CYC(16)
	) dut (.clk_sys, .rstn, .hard_reset_sent, .hard_reset_received, .vbus_at_safe_zero_level,
		.vbus_at_safe_default_level, .supply_reset_cmd, .vbus_enable, .sequence_busy,
		.sequence_done, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
	phrs_far_end u_far (.clk_sys, .rstn, .hr_go, .slow, .supply_reset_cmd, .vbus_enable,
		.hard_reset_received, .vbus_at_safe_zero_level, .vbus_at_safe_default_level);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// ----
	// bus and check tasks
	// ----
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic pulse(input logic rx);
		@(posedge clk_sys);
		hr_go <= rx;
		hard_reset_sent <= !rx;
		@(posedge clk_sys);
		hr_go <= 1'b0;
		hard_reset_sent <= 1'b0;
	endtask
	// bounded so a stuck sequence ends in a mismatch, not a hang
	task automatic idle_wait;
		for (int k = 0; k < 300 && sequence_busy; k++) @(posedge clk_sys);
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			error_cnt++;
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// ----
	// sequence of tests
	// ----
	initial begin
		rstn = 1'b0;
		hard_reset_sent = 1'b0;
		hr_go = 1'b0;
		slow = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(`PHRS_REG_CTRL);
		chk("ctrl", `PHRS_CTRL_RESET_VAL, v);
		rd(`PHRS_REG_IRQ_MASK);
		chk("mask", 32'h0, v);
		rd(4'h7);
		chk("unmapped", 32'h0, v);
		chk("vbus_enable", 32'h1, 32'(vbus_enable));
		chk("supply_reset_cmd", 32'h0, 32'(supply_reset_cmd));
		$display("test reset done");
		foreach (rows[i]) begin
			wr(`PHRS_REG_CTRL, 32'(rows[i].en));
			slow <= rows[i].slw;
			pulse(rows[i].rx);
			repeat (3) @(posedge clk_sys);
			pulse(1'b0);
			#1 chk("busy", 32'(rows[i].bsy), 32'(sequence_busy));
			idle_wait();
			chk("idle", 32'h0, 32'(sequence_busy));
			chk("vbus", 32'h1, 32'(vbus_enable));
			rd(`PHRS_REG_IRQ_STAT);
			chk("stat", 32'(rows[i].stat), v & 32'(rows[i].msk));
			chk("irq", 32'(rows[i].stat != 4'h0), 32'(irq));
			wr(`PHRS_REG_IRQ_STAT, 32'hf);
			rd(`PHRS_REG_IRQ_STAT);
			chk("stat_clr", 32'h0, v);
			$display("test row %0d done", i);
		end
		wr(`PHRS_REG_IRQ_MASK, 32'hf);
		pulse(1'b0);
		repeat (2) @(posedge clk_sys);
		idle_wait();
		chk("irq_masked", 32'h0, 32'(irq));
		wr(`PHRS_REG_IRQ_MASK, 32'h0);
		chk("irq_unmasked", 32'h1, 32'(irq));
		$display("test mask done");
		report_and_stop();
	end
endmodule // phrs_sequencer_test
